//--- pkg/sync_rx_defs.svh
// Constants shared by the synchronous receive link: register indices,
// field positions, reset values and link timing.
// Assumes it is included by bare name from every file that needs it.
//
// Functional notes
// - Single receive enable ignored in slave mode.
// - Continuous receive keeps working during sleep.
// - Complete word moves from shift to buffer.
// - Enabled receive interrupt wakes device from sleep.
// - Global enable branches to vector 0004h.
// - Software sets data direction, clears clock direction.
// - Software sets sync and enable, clears source.
// - Nine-bit select chooses 9-bit else 8-bit words.
// - Receive only while continuous enable is set.
// - Flag on completion; interrupt only when enabled.
// - Software reads status before data buffer.
// - Clearing continuous enable clears pending error.
// - Data sampled on shift clock falling edge.
// - Two-deep buffer; third word sets overrun.
// - Flag read-only, cleared when buffer empties.
// - Ninth bit buffered; data read advances it.
`ifndef SYNC_RX_DEFS_SVH
`define SYNC_RX_DEFS_SVH

// Device register indices on the device's own register port.
`define SRX_IDX_FLAGS 3'h0
`define SRX_IDX_STATUS 3'h1
`define SRX_IDX_DATA 3'h2
`define SRX_IDX_TXCTL 3'h3
`define SRX_IDX_IE 3'h4
`define SRX_IDX_PORTDIR 3'h5

// Field positions.
`define SRX_FLAG_RX 5
`define SRX_ST_SERIAL_PORT_ENABLE 7
`define SRX_ST_RX9 6
`define SRX_ST_SINGLE_RECEIVE_ENABLE 5
`define SRX_ST_CONTINUOUS_RECEIVE_ENABLE 4
`define SRX_ST_OVERRUN_ERROR_FLAG 1
`define SRX_ST_RECEIVED_NINTH_BIT 0
`define SRX_TX_CLOCK_SOURCE_SELECT 7
`define SRX_TX_SYNC 4
`define SRX_IE_RX 5
`define SRX_DIR_DATA 1
`define SRX_DIR_CLK 2

// Reset values and the interrupt vector.
`define SRX_RST_BYTE 8'h00
`define SRX_RST_WORD 9'h000
`define SRX_IRQ_VECTOR 16'h0004

// Word lengths in bits.
`define SRX_WORD_SHORT 4'h8
`define SRX_WORD_LONG 4'h9

// Controller register byte offsets on the Avalon-MM slave.
`define HST_OFF_TXDATA 4'h0
`define HST_OFF_STATUS 4'h4
`define HST_OFF_CONFIG 4'h8
`define HST_ST_BUSY 0
`define HST_CFG_NINE 0

// Link timing: shift clock period and local clock period in ns.
`define LNK_PERIOD_NS 160
`define REF_PERIOD_NS 4
`define LNK_HALF_CYCLES (`LNK_PERIOD_NS / (2 * `REF_PERIOD_NS))

`endif

//--- pkg/sync_rx_pkg.sv
// Types for the synchronous receive link, one used by each end.
// Assumes the constants header is compiled alongside.
package sync_rx_pkg;

   // Controller shift sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001, // Clock parked high, no word in flight.
      ST_HIGH = 3'b010, // Clock high half, data settles.
      ST_LOW = 3'b100 // Clock low half, after the sampling edge.
   } hst_state_t;

   // One received word: ninth bit above eight data bits.
   typedef logic [8:0] rx_word_t;

endpackage

//--- pkg/sync_rx_link_if.sv
// Link between the synchronous master and the slave receiver.
// Assumes the master drives both wires; the slave only listens.
`timescale 1ns/1ps
interface sync_rx_link_if;
   logic serial_clock_pin; // Shift clock, driven by the master.
   logic serial_data_pin; // Serial data, driven by the master.

   // Master end drives clock and data.
   modport master (output serial_clock_pin, output serial_data_pin);
   // Slave end receives clock and data.
   modport slave (input serial_clock_pin, input serial_data_pin);
endinterface // sync_rx_link_if

//--- logic/sync_rx_sync2.sv
// Two-flop level synchroniser into the clock it is given.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/1ps
module sync_rx_sync2
(
   input wire logic clk, // Destination clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic d, // Level from another domain.
   output logic q // Synchronised level.
);
   logic meta_r; // First stage, read only by the second stage.

   // Two stages give metastability time to settle.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= 1'b0;
         q <= 1'b0;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // sync_rx_sync2

//--- logic/sync_rx_device.sv
// Slave receiver end: shift logic on the link clock, register file
// and two-deep receive buffer on the local clock.
// Assumes the master on the link drives the shift clock and data.
//
// The implementer's own choices: the strobed register port and the register indices.
`timescale 1ns/1ps
`include "sync_rx_defs.svh"
module sync_rx_device #(
   parameter int FIFO_DEPTH = 2 // Words held in the receive buffer.
)
(
   input wire logic ref_clk, // Local clock.
   input wire logic rst, // Asynchronous reset, active high.
   sync_rx_link_if.slave lnk, // Serial link from the master.
   input wire logic [2:0] reg_addr, // Register index.
   input wire logic reg_wr, // Write strobe, one cycle.
   input wire logic reg_rd, // Read strobe, one cycle.
   input wire logic [7:0] reg_wdata, // Write data.
   input wire logic global_int_enable, // Global interrupt enable.
   input wire logic sleep_mode, // Core is asleep.
   output logic [7:0] reg_rdata, // Read data, one cycle after strobe.
   output logic irq, // Receive interrupt request.
   output logic wake, // Wake request out of sleep.
   output logic branch_req, // Branch to the interrupt vector.
   output logic [15:0] branch_vector // Vector address while branching.
);
   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CW = $clog2(FIFO_DEPTH + 1);

   // The buffer pointers and count are sized from the depth.
   if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255)
   begin : g_depth_check
      $error("FIFO_DEPTH must lie between 1 and 255.");
   end

   // True when the register port addresses the given index.
   function automatic logic hit(input logic [2:0] a, input logic [2:0] i);
      hit = (a == i);
   endfunction

   // Next pointer value, wrapping at the buffer depth.
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   logic [7:0] status_r; // Status bits; the link side reads one via sync.
   logic nine_lnk; // Nine-bit select as seen on the link clock.
   logic [8:0] shift_r; // Receive shift register.
   logic [8:0] shift_nxt; // Shift register with this edge's bit in.
   logic [3:0] bit_cnt_r; // Bits of the current word taken so far.
   logic [3:0] last_bit; // Index of the final bit of a word.
   sync_rx_pkg::rx_word_t word_r; // Completed word, held for crossing.
   logic word_tog_r; // Toggles once per completed word.

   // The word length is a quiet setting; it must be changed only
   // between words, and it takes two shift clocks to arrive here.
   sync_rx_sync2 u_nine_sync (
      .clk(lnk.serial_clock_pin),
      .rst(rst),
      .d(status_r[`SRX_ST_RX9]),
      .q(nine_lnk)
   );

   // The bit count ends a word after eight or nine bits.
   always_comb
   begin
      last_bit = nine_lnk ? (`SRX_WORD_LONG - 4'h1)
                          : (`SRX_WORD_SHORT - 4'h1);
      shift_nxt = shift_r;
      shift_nxt[bit_cnt_r] = lnk.serial_data_pin;
   end

   // Shifting runs on the external clock alone, so it goes on while
   // the core sleeps and the local clock may be idle.
   always_ff @(negedge lnk.serial_clock_pin or posedge rst)
   begin
      if (rst)
      begin
         shift_r <= `SRX_RST_WORD;
         bit_cnt_r <= 4'h0;
      end
      else
      begin
         shift_r <= shift_nxt;
         bit_cnt_r <= (bit_cnt_r == last_bit) ? 4'h0
                                              : bit_cnt_r + 4'h1;
      end
   end

   // A finished word is parked in word_r and announced by a toggle;
   // it stays stable for at least eight shift clocks, far longer than
   // the local side needs to take it.
   always_ff @(negedge lnk.serial_clock_pin or posedge rst)
   begin
      if (rst)
      begin
         word_r <= `SRX_RST_WORD;
         word_tog_r <= 1'b0;
      end
      else if (bit_cnt_r == last_bit)
      begin
         word_r <= nine_lnk ? shift_nxt : {1'b0, shift_nxt[7:0]};
         word_tog_r <= ~word_tog_r;
      end
   end

   logic tog_s; // Word toggle, synchronised into the local clock.
   logic tog_d_r; // Previous synchronised toggle.
   logic word_evt; // One cycle per completed word.
   logic [7:0] txctl_r; // Mode bits: source select and sync mode.
   logic [7:0] ie_r; // Interrupt enable bits.
   logic [7:0] portdir_r; // Pin direction bits.
   logic overrun_error_flag_r; // Overrun error flag.
   logic rx_on; // Reception is allowed.
   logic full; // Buffer holds FIFO_DEPTH words.
   logic push; // Word goes into the buffer.
   logic ovr; // Word arrives with no room.
   logic pop; // Software read of the data buffer.
   logic int_now; // Flag and enable both set.
   logic head9; // Ninth bit of the word at the head.
   sync_rx_pkg::rx_word_t fifo_mem [FIFO_DEPTH]; // Receive buffer.
   logic [PW-1:0] wp_r; // Write pointer.
   logic [PW-1:0] rp_r; // Read pointer.
   logic [CW-1:0] cnt_r; // Words held.

   sync_rx_sync2 u_tog_sync (
      .clk(ref_clk),
      .rst(rst),
      .d(word_tog_r),
      .q(tog_s)
   );

   // Edge detect on the synchronised toggle.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         tog_d_r <= 1'b0;
      else
         tog_d_r <= tog_s;
   end

   // The single receive enable plays no part here; the pins must be
   // handed to the port and the mode must be synchronous slave.
   always_comb
   begin
      word_evt = tog_s ^ tog_d_r;
      rx_on = status_r[`SRX_ST_SERIAL_PORT_ENABLE] & txctl_r[`SRX_TX_SYNC]
            & ~txctl_r[`SRX_TX_CLOCK_SOURCE_SELECT]
            & portdir_r[`SRX_DIR_DATA] & ~portdir_r[`SRX_DIR_CLK]
            & status_r[`SRX_ST_CONTINUOUS_RECEIVE_ENABLE];
      full = (cnt_r == CW'(FIFO_DEPTH));
      push = word_evt & rx_on & ~overrun_error_flag_r & ~full;
      ovr = word_evt & rx_on & ~overrun_error_flag_r & full;
      pop = reg_rd & hit(reg_addr, `SRX_IDX_DATA) & (cnt_r != '0);
      int_now = (cnt_r != '0) & ie_r[`SRX_IE_RX];
      head9 = (cnt_r != '0) ? fifo_mem[rp_r][8] : 1'b0;
   end

   // Software-written control registers.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         status_r <= `SRX_RST_BYTE;
         txctl_r <= `SRX_RST_BYTE;
         ie_r <= `SRX_RST_BYTE;
         portdir_r <= `SRX_RST_BYTE;
      end
      else if (reg_wr)
      begin
         // Flag and error bits of these registers are not stored.
         if (hit(reg_addr, `SRX_IDX_STATUS))
            status_r <= {reg_wdata[7:3], 3'h0};
         if (hit(reg_addr, `SRX_IDX_TXCTL))
            txctl_r <= reg_wdata;
         if (hit(reg_addr, `SRX_IDX_IE))
            ie_r <= reg_wdata;
         if (hit(reg_addr, `SRX_IDX_PORTDIR))
            portdir_r <= reg_wdata;
      end
   end

   // Overrun sets on a word with no room and blocks further transfers
   // until the continuous enable is cleared; the set wins a tie.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         overrun_error_flag_r <= 1'b0;
      else if (ovr)
         overrun_error_flag_r <= 1'b1;
      else if (!status_r[`SRX_ST_CONTINUOUS_RECEIVE_ENABLE])
         overrun_error_flag_r <= 1'b0;
   end

   // Buffer storage; each entry keeps its ninth bit with the data.
   always_ff @(posedge ref_clk)
   begin
      if (push)
         fifo_mem[wp_r] <= word_r;
   end

   // Buffer pointers and count; a push and a pop may share a cycle.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= ptr_inc(wp_r);
         if (pop)
            rp_r <= ptr_inc(rp_r);
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end

   // Register reads answer one cycle after the strobe. The flag is
   // the buffer's non-empty state, so writes cannot touch it.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= `SRX_RST_BYTE;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `SRX_IDX_FLAGS:
            begin
               reg_rdata <= `SRX_RST_BYTE;
               reg_rdata[`SRX_FLAG_RX] <= (cnt_r != '0);
            end
            `SRX_IDX_STATUS:
            begin
               // Reading status first keeps the ninth bit safe.
               reg_rdata <= status_r;
               reg_rdata[`SRX_ST_OVERRUN_ERROR_FLAG] <= overrun_error_flag_r;
               reg_rdata[`SRX_ST_RECEIVED_NINTH_BIT] <= head9;
            end
            `SRX_IDX_DATA:
               reg_rdata <= (cnt_r != '0) ? fifo_mem[rp_r][7:0]
                                          : `SRX_RST_BYTE;
            `SRX_IDX_TXCTL:
               reg_rdata <= txctl_r;
            `SRX_IDX_IE:
               reg_rdata <= ie_r;
            `SRX_IDX_PORTDIR:
               reg_rdata <= portdir_r;
            default:
               reg_rdata <= `SRX_RST_BYTE;
         endcase
      end
   end

   // Interrupt, wake and branch requests follow the flag by a cycle.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irq <= 1'b0;
         wake <= 1'b0;
         branch_req <= 1'b0;
         branch_vector <= 16'h0000;
      end
      else
      begin
         irq <= int_now;
         wake <= int_now & sleep_mode;
         branch_req <= int_now & global_int_enable;
         branch_vector <= (int_now & global_int_enable)
                          ? `SRX_IRQ_VECTOR : 16'h0000;
      end
   end
endmodule // sync_rx_device

//--- logic/sync_rx_master.sv
// Synchronous master end: software queues words over Avalon-MM and
// this end clocks them out, deriving the shift clock by a divider.
// Assumes the slave samples data on the falling shift clock edge.
`timescale 1ns/1ps
`include "sync_rx_defs.svh"
module sync_rx_master #(
   parameter int HALF_CYCLES = `LNK_HALF_CYCLES // Local clocks per half.
)
(
   input wire logic ref_clk, // Local clock.
   input wire logic rst, // Asynchronous reset, active high.
   sync_rx_link_if.master lnk, // Serial link to the slave.
   input wire logic [3:0] address, // Avalon byte address.
   input wire logic read, // Avalon read.
   input wire logic write, // Avalon write.
   input wire logic [31:0] writedata, // Avalon write data.
   output logic [31:0] readdata, // Avalon read data.
   output logic waitrequest // Avalon wait, high until accepted.
);
   // The divider count must fit its counter and be at least one.
   if (HALF_CYCLES < 1 || HALF_CYCLES > 65535)
   begin : g_half_check
      $error("HALF_CYCLES must lie between 1 and 65535.");
   end

   sync_rx_pkg::hst_state_t state_r; // Shift sequencer state.
   logic [15:0] div_r; // Half-period counter.
   logic [8:0] tx_r; // Word being sent, ninth bit on top.
   logic [3:0] bit_r; // Bits clocked so far.
   logic nine_r; // Word length select, matched to the slave.
   logic sclk_r; // Shift clock flop.
   logic sdata_r; // Data flop.
   logic busy; // Word in flight.
   logic req; // Avalon request present.
   logic stall; // Data write while busy must wait.
   logic accept; // Request completes at this edge.
   logic start; // Data write accepted.
   logic half_done; // Half period complete.

   assign lnk.serial_clock_pin = sclk_r;
   assign lnk.serial_data_pin = sdata_r;

   always_comb
   begin
      busy = (state_r != sync_rx_pkg::ST_IDLE);
      req = read | write;
      stall = write & (address == `HST_OFF_TXDATA) & busy;
      accept = req & ~waitrequest;
      start = accept & write & (address == `HST_OFF_TXDATA);
      half_done = (div_r == 16'(HALF_CYCLES - 1));
   end

   // Wait drops for one cycle a cycle after a request; a data write
   // is held off while a word is in flight, which back-pressures
   // software instead of dropping its word.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         waitrequest <= 1'b1;
      else if (!waitrequest)
         waitrequest <= 1'b1;
      else
         waitrequest <= ~(req & ~stall);
   end

   // Read data is set up as wait drops and stands at the accept edge.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         readdata <= 32'h0000_0000;
      else if (read && waitrequest)
      begin
         unique case (address)
            `HST_OFF_TXDATA: readdata <= {23'h00_0000, tx_r};
            `HST_OFF_STATUS: readdata <= {31'h0000_0000, busy};
            `HST_OFF_CONFIG: readdata <= {31'h0000_0000, nine_r};
            default: readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Word length setting.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         nine_r <= 1'b0;
      else if (accept && write && address == `HST_OFF_CONFIG)
         nine_r <= writedata[`HST_CFG_NINE];
   end

   // Shift sequencer: data changes while the clock is high, so it is
   // settled half a period before the slave's falling-edge sample.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= sync_rx_pkg::ST_IDLE;
         div_r <= 16'h0000;
         tx_r <= 9'h000;
         bit_r <= 4'h0;
         sclk_r <= 1'b1;
         sdata_r <= 1'b0;
      end
      else
      begin
         unique case (state_r)
            sync_rx_pkg::ST_IDLE:
            begin
               if (start)
               begin
                  tx_r <= writedata[8:0];
                  sdata_r <= writedata[0];
                  bit_r <= 4'h0;
                  div_r <= 16'h0000;
                  state_r <= sync_rx_pkg::ST_HIGH;
               end
            end
            sync_rx_pkg::ST_HIGH:
            begin
               if (!half_done)
                  div_r <= div_r + 16'h0001;
               else if (bit_r == (nine_r ? `SRX_WORD_LONG
                                         : `SRX_WORD_SHORT))
                  state_r <= sync_rx_pkg::ST_IDLE;
               else
               begin
                  div_r <= 16'h0000;
                  sclk_r <= 1'b0;
                  state_r <= sync_rx_pkg::ST_LOW;
               end
            end
            sync_rx_pkg::ST_LOW:
            begin
               if (!half_done)
                  div_r <= div_r + 16'h0001;
               else
               begin
                  div_r <= 16'h0000;
                  sclk_r <= 1'b1;
                  bit_r <= bit_r + 4'h1;
                  sdata_r <= tx_r[(bit_r == 4'h8) ? 4'h8
                                                  : bit_r + 4'h1];
                  state_r <= sync_rx_pkg::ST_HIGH;
               end
            end
         endcase
      end
   end
endmodule // sync_rx_master

//--- tb/sync_rx_monitor.sv
// Link checker: watches the shift clock and data wires of the link.
// Assumes the master runs with HALF_CYCLES of 4 on the local clock.
`timescale 1ns/1ps
module sync_rx_monitor #(
   parameter int HALF_CYCLES = 4 // Local clocks per shift clock half.
)
(
   input wire logic ref_clk, // Local clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic serial_clock_pin, // Shift clock on the link.
   input wire logic serial_data_pin // Serial data on the link.
);
   logic clk_q_r; // Shift clock one local cycle ago.
   logic [3:0] hi_cnt_r; // Cycles the shift clock has stood high.
   logic [3:0] fall_cnt_r; // Falling edges seen in this word.
   logic word_end; // High for longer than a half, so the word is over.
   assign word_end = (hi_cnt_r == 4'(HALF_CYCLES + 1));

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // Delay the shift clock to find its falling edges.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         clk_q_r <= 1'b1;
      else
         clk_q_r <= serial_clock_pin;
   end

   // Measure the high run; it saturates so long idle spans stay sane.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         hi_cnt_r <= 4'h0;
      else if (!serial_clock_pin)
         hi_cnt_r <= 4'h0;
      else if (hi_cnt_r != 4'hF)
         hi_cnt_r <= hi_cnt_r + 4'h1;
   end

   // Count falling edges; a long high run closes the word.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         fall_cnt_r <= 4'h0;
      else if (word_end)
         fall_cnt_r <= 4'h0;
      else if (clk_q_r && !serial_clock_pin)
         fall_cnt_r <= fall_cnt_r + 4'h1;
   end

   // The repetition counts below are the bench's half period of 4.
   a_reset_idle: assert property ($fell(rst) |-> serial_clock_pin
      && !serial_data_pin) else $error("link not idle after reset");
   a_data_at_fall: assert property ($fell(serial_clock_pin) |->
      $stable(serial_data_pin)) else $error("data moved at fall");
   a_data_moves_high: assert property ($changed(serial_data_pin) |->
      serial_clock_pin) else $error("data moved with clock low");
   a_low_half: assert property ($fell(serial_clock_pin) |->
      !serial_clock_pin [*4] ##1 serial_clock_pin)
      else $error("low half has wrong length");
   a_high_half: assert property ($rose(serial_clock_pin) |->
      serial_clock_pin [*4]) else $error("high half too short");
   a_bit_gap: assert property ($fell(serial_clock_pin)
      && fall_cnt_r < 4'h7 |-> ##8 $fell(serial_clock_pin))
      else $error("bit spacing wrong inside a word");
   a_word_bits: assert property (word_end && fall_cnt_r != 4'h0 |->
      fall_cnt_r inside {4'h8, 4'h9}) else $error("word length wrong");
   a_bit_limit: assert property (fall_cnt_r <= 4'h9)
      else $error("more than nine bits in a word");

   c_short_word: cover property (word_end && fall_cnt_r == 4'h8);
   c_long_word: cover property (word_end && fall_cnt_r == 4'h9);
   c_reset_out: cover property ($fell(rst));
endmodule // sync_rx_monitor

//--- tb/sync_slave_serial_receiver_tb_top.sv
// Bench joining master and receiver ends over the link interface.
// Assumes the master's shift clock half is shortened to 4 clocks.
`timescale 1ns/1ps
`include "sync_rx_defs.svh"
module sync_slave_serial_receiver_tb_top;
   logic ref_clk, rst, reg_wr, reg_rd, irq, wake, branch_req;
   logic global_int_enable, sleep_mode, read, write, waitrequest;
   logic [2:0] reg_addr; // Device register index.
   logic [7:0] reg_wdata, reg_rdata; // Device register data.
   logic [15:0] branch_vector; // Vector while branching.
   logic [3:0] address; // Avalon byte address.
   logic [31:0] writedata, readdata, v; // Avalon data.
   int error_cnt = 0; // Mismatches seen.
   int compares = 0; // Comparisons made.

   sync_rx_link_if lnk();
   sync_rx_device u_sync_rx_device (.ref_clk(ref_clk), .rst(rst),
      .lnk(lnk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .global_int_enable(global_int_enable),
      .sleep_mode(sleep_mode), .reg_rdata(reg_rdata), .irq(irq),
      .wake(wake), .branch_req(branch_req),
      .branch_vector(branch_vector));
   sync_rx_master #(.HALF_CYCLES(4)) u_sync_rx_master (.ref_clk(ref_clk),
      .rst(rst), .lnk(lnk), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest));
   sync_rx_monitor #(.HALF_CYCLES(4)) u_sync_rx_monitor (
      .ref_clk(ref_clk), .rst(rst),
      .serial_clock_pin(lnk.serial_clock_pin),
      .serial_data_pin(lnk.serial_data_pin));

   // Free-running local clock at 250 MHz.
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Compare with case equality so an unknown never matches.
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Device register write; an idle edge follows so strobes never merge.
   task rw(input logic [2:0] i, input logic [7:0] d);
      reg_addr <= i;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Device register read; data is taken one edge after the strobe.
   task rchk(input logic [2:0] i, input logic [7:0] e);
      reg_addr <= i;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      chk(reg_rdata, e);
   endtask

   // Avalon access: request held until waitrequest is seen low.
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      v = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Queue a word, poll busy until the link is quiet, let it cross.
   task snd(input logic [8:0] w);
      int n;
      n = 0;
      av(1'b1, 4'h0, {23'h0, w});
      do
      begin
         av(1'b0, 4'h4, 32'h0000_0000);
         n++;
      end
      while (v[0] !== 1'b0 && n < 400);
      // A link that never goes quiet counts against the run.
      if (v[0] !== 1'b0)
         error_cnt++;
      repeat (8) @(posedge ref_clk);
   endtask

   // Hang guard, well beyond the several hundred cycles the tests need.
   initial
   begin
      #100000;
      error_cnt++;
      end_sim;
   end

   initial
   begin
      rst = 1'b1;
      {reg_wr, reg_rd, read, write} = 4'h0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      address = 4'h0;
      writedata = 32'h0000_0000;
      global_int_enable = 1'b1; // Branching is enabled except for one masked check.
      sleep_mode = 1'b1; // The core sleeps except for one awake check; the local clock keeps running.
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rchk(`SRX_IDX_FLAGS, 8'h00);
      rchk(`SRX_IDX_STATUS, 8'h00);
      rw(`SRX_IDX_PORTDIR, 8'h02);
      rw(`SRX_IDX_TXCTL, 8'h10);
      rw(`SRX_IDX_IE, 8'h20);
      rw(`SRX_IDX_STATUS, 8'hB0);
      snd(9'h0A5);
      rchk(`SRX_IDX_FLAGS, 8'h20);
      chk({irq, wake, branch_req}, 16'h0007);
      chk(branch_vector, `SRX_IRQ_VECTOR);
      // An awake core with branching masked sees neither request.
      sleep_mode <= 1'b0;
      global_int_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk({irq, wake, branch_req}, 16'h0004);
      chk(branch_vector, 16'h0000);
      sleep_mode <= 1'b1;
      global_int_enable <= 1'b1;
      rchk(`SRX_IDX_STATUS, 8'hB0);
      rchk(`SRX_IDX_DATA, 8'hA5);
      rchk(`SRX_IDX_FLAGS, 8'h00);
      chk({irq, wake, branch_req}, 16'h0000);
      // Nine-bit words back to back fill the two-deep buffer.
      rw(`SRX_IDX_STATUS, 8'hD0);
      av(1'b1, 4'h8, 32'h0000_0001);
      av(1'b1, 4'h0, 32'h0000_013C);
      snd(9'h0C3);
      rchk(`SRX_IDX_STATUS, 8'hD1);
      rchk(`SRX_IDX_DATA, 8'h3C);
      rchk(`SRX_IDX_STATUS, 8'hD0);
      rchk(`SRX_IDX_DATA, 8'hC3);
      // A third word with the buffer full overruns and blocks more.
      av(1'b1, 4'h0, 32'h0000_0111);
      av(1'b1, 4'h0, 32'h0000_0022);
      snd(9'h033);
      rchk(`SRX_IDX_STATUS, 8'hD3);
      rchk(`SRX_IDX_DATA, 8'h11);
      snd(9'h044);
      rchk(`SRX_IDX_STATUS, 8'hD2);
      rchk(`SRX_IDX_DATA, 8'h22);
      rchk(`SRX_IDX_FLAGS, 8'h00);
      rw(`SRX_IDX_STATUS, 8'hC0);
      rw(`SRX_IDX_STATUS, 8'hD0);
      rchk(`SRX_IDX_STATUS, 8'hD0);
      // Single enable alone does not receive.
      rw(`SRX_IDX_STATUS, 8'hE0);
      snd(9'h155);
      rchk(`SRX_IDX_FLAGS, 8'h00);
      // With the interrupt masked the flag rises but no request.
      rw(`SRX_IDX_IE, 8'h00);
      rw(`SRX_IDX_STATUS, 8'hD0);
      snd(9'h1AA);
      rchk(`SRX_IDX_FLAGS, 8'h20);
      chk({irq, wake, branch_req}, 16'h0000);
      rchk(`SRX_IDX_STATUS, 8'hD1);
      rchk(`SRX_IDX_DATA, 8'hAA);
      rchk(`SRX_IDX_DATA, 8'h00);
      av(1'b0, 4'h0, 32'h0000_0000);
      chk(v[15:0], 16'h01AA);
      av(1'b0, 4'hC, 32'h0000_0000);
      chk(v[15:0], 16'h0000);
      end_sim;
   end
endmodule // sync_slave_serial_receiver_tb_top
